// [sccr_pkg.sv]
package sccr_pkg;
  localparam logic [7:0]  SCCR_OFFSET      = 8'h1C;
  localparam int          SCCR_USB_CLK_BIT = 3;
  localparam int          SCCR_DEEP_BIT    = 4;
  localparam int          SCCR_LEGACY_BIT  = 5;
  localparam int          SCCR_XTAL_BIT    = 6;
  localparam logic [7:0]  SCCR_FUNC_MASK   = 8'h78;
  localparam logic [7:0]  SCCR_RESET       = 8'h00;
  localparam logic [1:0]  SCCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SCCR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic crystal_frequency_select;
    logic legacy_port_mode_flag;
    logic deep_suspend_power_down;
    logic usb_clock_enable;
  } sccr_ctrl_t;
endpackage

// [sccr_tb.sv]
`timescale 1ns/1ps
module system_clock_control_register_tb_top;
  import sccr_pkg::*;
  logic        clock_i, srst_i, awv, wv, bq, arv, rq;
  logic        aw_r, w_r, bv, ar_r, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, r;
  wire  [4:0]  o;
  int          fails, comparisons;

  always #25 clock_i = ~clock_i;

  sccr_top DUT (
    .clock_i(clock_i), .srst_i(srst_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_r), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(w_r),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bq),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_r),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rq), .usb_clock_enable_o(o[0]),
    .deep_suspend_power_down_o(o[1]), .legacy_port_mode_flag_o(o[2]),
    .crystal_frequency_select_o(o[3]), .suspend_detect_ready_o(o[4])
  );

  // expected pin levels for a stored byte
  function automatic logic [4:0] outs(input logic [7:0] v);
    return {v[3] & ~v[4], v[6:3]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [3:0] s);
    @(posedge clock_i);
    awa <= a;
    wd  <= {24'hA5A5A5, v};
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    bq  <= 1'b1;
    do begin
      @(posedge clock_i);
      if (aw_r) awv <= 1'b0;
      if (w_r) wv <= 1'b0;
    end while (!(bv && bq));
    r = bresp;
    bq <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    ara <= a;
    arv <= 1'b1;
    rq  <= 1'b1;
    do begin
      @(posedge clock_i);
      if (ar_r) arv <= 1'b0;
    end while (!(rv && rq));
    d = rdat;
    r = rresp;
    rq <= 1'b0;
  endtask

  task automatic t_reset;
    chk("pins", 5'h00, o);
    chk("ready", 3'h7, {aw_r, w_r, ar_r});
    rd(SCCR_OFFSET);
    chk("rdata", 32'h0, d);
    $display("t_reset done");
  endtask

  task automatic t_bits;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 8'h08 << i;
      wr(SCCR_OFFSET, v, 4'hF);
      chk("bresp", SCCR_RESP_OKAY, r);
      chk("pins", outs(v), o);
      rd(SCCR_OFFSET);
      chk("rdata", v, d);
      chk("rresp", SCCR_RESP_OKAY, r);
    end
    wr(SCCR_OFFSET, 8'h78, 4'hF);
    chk("pins", 5'h0F, o);
    rd(SCCR_OFFSET);
    rd(SCCR_OFFSET);
    chk("rdata", 32'h78, d);
    $display("t_bits done");
  endtask

  task automatic t_miss;
    wr(8'h20, 8'h00, 4'hF);
    chk("bresp", SCCR_RESP_SLVERR, r);
    chk("pins", 5'h0F, o);
    rd(8'h20);
    chk("rresp", SCCR_RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    wr(SCCR_OFFSET, 8'h00, 4'h0);
    chk("pins", 5'h0F, o);
    wr(SCCR_OFFSET, 8'h00, 4'h1);
    chk("pins", 5'h00, o);
    $display("t_miss done");
  endtask

  task automatic t_rst;
    wr(SCCR_OFFSET, 8'h78, 4'h1);
    chk("pins", 5'h0F, o);
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    chk("pins", 5'h00, o);
    rd(SCCR_OFFSET);
    chk("rdata", 32'h0, d);
    $display("t_rst done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {clock_i, awv, wv, bq, arv, rq, awa, ara, wd, ws} = '0;
    srst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_bits();
    t_miss();
    t_rst();
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge clock_i);
    fails++;
    finish_test();
  end
endmodule

// [sccr_top.sv]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module sccr_top
  import sccr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             usb_clock_enable_o,
  output logic             deep_suspend_power_down_o,
  output logic             legacy_port_mode_flag_o,
  output logic             crystal_frequency_select_o,
  output logic             suspend_detect_ready_o
);

  sccr_ctrl_t ctrl;
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[7:2] == SCCR_OFFSET[7:2]);
  endfunction

  function automatic logic [7:0] pack_reg(input sccr_ctrl_t c);
    logic [7:0] r;
    r = 8'h00;
    r[SCCR_USB_CLK_BIT] = c.usb_clock_enable;
    r[SCCR_DEEP_BIT]    = c.deep_suspend_power_down;
    r[SCCR_LEGACY_BIT]  = c.legacy_port_mode_flag;
    r[SCCR_XTAL_BIT]    = c.crystal_frequency_select;
    pack_reg = r;
  endfunction

  // address and data are latched independently, in either order
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  logic       aw_now;
  logic       w_now;
  logic       wr_go;
  logic       wr_hit;
  logic [7:0] eff_addr;
  logic [7:0] eff_data;
  logic       eff_lane0;
  assign aw_now    = aw_held || (s_axi_awvalid_i && s_axi_awready_o);
  assign w_now     = w_held || (s_axi_wvalid_i && s_axi_wready_o);
  assign wr_go     = aw_now && w_now && !s_axi_bvalid_o;
  assign eff_addr  = aw_held ? aw_addr : s_axi_awaddr_i;
  assign eff_data  = w_held ? w_byte : s_axi_wdata_i[7:0];
  assign eff_lane0 = w_held ? w_lane0 : s_axi_wstrb_i[0];
  // a write touches the bits only with a mapped address and low lane on
  assign wr_hit    = wr_go && addr_hit(eff_addr) && eff_lane0;

  always_ff @(posedge clock_i) begin
    if (srst_i || wr_go) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i || wr_go) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata_i[7:0];
      w_lane0 <= s_axi_wstrb_i[0];
    end
  end

  // one write updates all four control bits together; unused bits drop
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl.usb_clock_enable         <= SCCR_RESET[SCCR_USB_CLK_BIT];
      ctrl.deep_suspend_power_down  <= SCCR_RESET[SCCR_DEEP_BIT];
      ctrl.legacy_port_mode_flag    <= SCCR_RESET[SCCR_LEGACY_BIT];
      ctrl.crystal_frequency_select <= SCCR_RESET[SCCR_XTAL_BIT];
    end else if (wr_hit) begin
      ctrl.usb_clock_enable         <= eff_data[SCCR_USB_CLK_BIT];
      ctrl.deep_suspend_power_down  <= eff_data[SCCR_DEEP_BIT];
      ctrl.legacy_port_mode_flag    <= eff_data[SCCR_LEGACY_BIT];
      ctrl.crystal_frequency_select <= eff_data[SCCR_XTAL_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= SCCR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= addr_hit(eff_addr) ? SCCR_RESP_OKAY
                                           : SCCR_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // reads have no side effect on the control bits
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= SCCR_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      if (addr_hit(s_axi_araddr_i)) begin
        s_axi_rdata_o <= {24'h00_0000, pack_reg(ctrl)};
        s_axi_rresp_o <= SCCR_RESP_OKAY;
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= SCCR_RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  assign usb_clock_enable_o         = ctrl.usb_clock_enable;
  assign deep_suspend_power_down_o  = ctrl.deep_suspend_power_down;
  assign legacy_port_mode_flag_o    = ctrl.legacy_port_mode_flag;
  assign crystal_frequency_select_o = ctrl.crystal_frequency_select;

  // registered with the bits so the indicator is a clean flop output
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      suspend_detect_ready_o <= SCCR_RESET[SCCR_USB_CLK_BIT] &&
                                !SCCR_RESET[SCCR_DEEP_BIT];
    end else if (wr_hit) begin
      suspend_detect_ready_o <= eff_data[SCCR_USB_CLK_BIT] &&
                                !eff_data[SCCR_DEEP_BIT];
    end
  end

  a_reset_clears: assert property (@(posedge clock_i)
    srst_i |=> (pack_reg(ctrl) == SCCR_RESET))
    else $error("control bits not cleared by reset");
  a_ready_reset: assert property (@(posedge clock_i)
    srst_i |=> s_axi_awready_o && s_axi_wready_o && s_axi_arready_o &&
    !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("bus not idle after reset");
  a_write_usb_clk: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_hit |=> usb_clock_enable_o == $past(eff_data[SCCR_USB_CLK_BIT]))
    else $error("usb clock enable not written");
  a_write_deep: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_hit |=> deep_suspend_power_down_o == $past(eff_data[SCCR_DEEP_BIT]))
    else $error("deep suspend bit not written");
  a_legacy_stable: assert property (@(posedge clock_i)
    disable iff (srst_i)
    !wr_hit |=> $stable(legacy_port_mode_flag_o))
    else $error("legacy flag changed without a write");
  a_write_legacy: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_hit |=> legacy_port_mode_flag_o == $past(eff_data[SCCR_LEGACY_BIT]))
    else $error("legacy flag not written");
  a_write_xtal: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_hit |=> crystal_frequency_select_o == $past(eff_data[SCCR_XTAL_BIT]))
    else $error("crystal select not written");
  a_miss_keeps: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_go && !addr_hit(eff_addr) |=> $stable(ctrl))
    else $error("unmapped write changed control bits");
  a_strobe_keeps: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_go && !eff_lane0 |=> $stable(ctrl))
    else $error("write without low byte lane changed control bits");
  a_write_resp: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_go |=> s_axi_bvalid_o && s_axi_bresp_o ==
    ($past(addr_hit(eff_addr)) ? SCCR_RESP_OKAY : SCCR_RESP_SLVERR))
    else $error("write response wrong");
  a_read_value: assert property (@(posedge clock_i)
    disable iff (srst_i)
    s_axi_arvalid_i && s_axi_arready_o && addr_hit(s_axi_araddr_i) |=>
    s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(pack_reg(ctrl)))
    else $error("read data does not match register");
  a_read_miss: assert property (@(posedge clock_i)
    disable iff (srst_i)
    s_axi_arvalid_i && s_axi_arready_o && !addr_hit(s_axi_araddr_i) |=>
    s_axi_rvalid_o && s_axi_rresp_o == SCCR_RESP_SLVERR &&
    s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read answered wrongly");
  a_read_no_effect: assert property (@(posedge clock_i)
    disable iff (srst_i)
    s_axi_rvalid_o && !wr_go |=> $stable(ctrl))
    else $error("read disturbed control bits");
  a_unused_zero: assert property (@(posedge clock_i)
    disable iff (srst_i)
    s_axi_rvalid_o |-> (s_axi_rdata_o[7:0] & ~SCCR_FUNC_MASK) == 8'h00)
    else $error("unused bits read nonzero");
  a_detect_ready: assert property (@(posedge clock_i)
    disable iff (srst_i)
    suspend_detect_ready_o |-> usb_clock_enable_o &&
    !deep_suspend_power_down_o)
    else $error("suspend detect ready wrong");
  a_detect_set: assert property (@(posedge clock_i)
    disable iff (srst_i)
    wr_hit |=> suspend_detect_ready_o ==
    ($past(eff_data[SCCR_USB_CLK_BIT]) && !$past(eff_data[SCCR_DEEP_BIT])))
    else $error("suspend detect ready not updated");

  c_write_hit: cover property (@(posedge clock_i)
    wr_go && addr_hit(eff_addr));
  c_write_miss: cover property (@(posedge clock_i)
    wr_go && !addr_hit(eff_addr));
  c_read_hit: cover property (@(posedge clock_i)
    s_axi_rvalid_o && s_axi_rresp_o == SCCR_RESP_OKAY);
  c_read_miss: cover property (@(posedge clock_i)
    s_axi_rvalid_o && s_axi_rresp_o == SCCR_RESP_SLVERR);
  c_detect: cover property (@(posedge clock_i) suspend_detect_ready_o);
endmodule
